// ==== hdl/qsof_pkg.sv ====
// Shared constants for the four-lane serial output formatter
package qsof_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned WORD_BITS       = 10;
  localparam int unsigned LANES           = 4;
  // Six bit-clock periods per frame, both edges used: twelve slots
  localparam int unsigned BIT_CLK_MULT    = 6;
  localparam int unsigned FRAME_SLOTS     = 2 * BIT_CLK_MULT;
  localparam int unsigned STUFF_BITS      = FRAME_SLOTS - WORD_BITS;
  localparam int unsigned MARK_HIGH_SLOTS = FRAME_SLOTS / 2;
  // Lowest sample rates, normal and low-rate PLL setting
  localparam int unsigned MIN_RATE_SPS    = 10_000_000;
  localparam int unsigned MIN_RATE_LO_SPS = 5_000_000;
  // Longest sample period in clk cycles, rounded down
  localparam int unsigned MAX_PERIOD_CYC    = CLK_HZ / MIN_RATE_SPS;
  localparam int unsigned MAX_PERIOD_LO_CYC = CLK_HZ / MIN_RATE_LO_SPS;
  // Shortest period: one clk cycle per serial slot
  localparam int unsigned MIN_PERIOD_CYC    = FRAME_SLOTS;
  localparam int unsigned PERIOD_W          = 8;
  // Strap is caught this many cycles after reset release, past its synchroniser
  localparam logic [1:0]  STRAP_CATCH_CYC   = 2'h3;
  // Coding constants
  localparam logic [9:0]  CODE_MIDSCALE     = 10'h200;
  localparam logic [9:0]  CODE_ALL_ONES     = 10'h3ff;
  localparam logic [9:0]  CODE_ALL_ZEROS    = 10'h000;
  localparam logic [9:0]  CODE_CHECKER_A    = 10'h2aa;
  localparam logic [9:0]  CODE_CHECKER_B    = 10'h155;
  localparam logic [9:0]  CODE_SYNC         = 10'h01f;
  localparam logic [9:0]  CODE_MIXED        = 10'h263;
  // Pseudorandom generators
  localparam int unsigned PN_LONG_W   = 23;
  localparam int unsigned PN_LONG_TAP = 18;
  localparam int unsigned PN_SHORT_W  = 9;
  localparam int unsigned PN_SHORT_TAP = 5;
  // Test mode codes
  typedef enum logic [3:0] {
    QSOF_TM_OFF       = 4'h0,
    QSOF_TM_MIDSCALE  = 4'h1,
    QSOF_TM_POS_FULL  = 4'h2,
    QSOF_TM_NEG_FULL  = 4'h3,
    QSOF_TM_CHECKER   = 4'h4,
    QSOF_TM_PN_LONG   = 4'h5,
    QSOF_TM_PN_SHORT  = 4'h6,
    QSOF_TM_WORD_TOG  = 4'h7,
    QSOF_TM_USER      = 4'h8,
    QSOF_TM_BIT_TOG   = 4'h9,
    QSOF_TM_SYNC      = 4'ha,
    QSOF_TM_ONE_HIGH  = 4'hb,
    QSOF_TM_MIXED     = 4'hc
  } qsof_test_mode_t;
endpackage

// ==== hdl/qsof_pn_gen.sv ====
// Pseudorandom word generator: advances one word of bits per step
`timescale 1ns/1ps
`default_nettype none
module qsof_pn_gen
  import qsof_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned TAP   = 5,
  parameter int unsigned OUT_W = 10
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             step,
  output logic      [OUT_W-1:0] word
);
  logic [WIDTH-1:0] state_reg;
  logic [WIDTH-1:0] state_next;
  logic [OUT_W-1:0] word_next;

  // Fibonacci shift register, feedback from the top stage and the tap
  always_comb begin
    state_next = state_reg;
    word_next  = '0;
    for (int i = 0; i < OUT_W; i++) begin
      word_next  = {word_next[OUT_W-2:0], state_next[WIDTH-1] ^ state_next[TAP-1]};
      state_next = {state_next[WIDTH-2:0], state_next[WIDTH-1] ^ state_next[TAP-1]};
    end
  end

  // All-ones seed; the all-zero lock-up state is never entered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '1;
      word      <= '1;
    end else if (step) begin
      state_reg <= state_next;
      word      <= word_next;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/qsof_formatter.sv ====
// Four-lane serial output formatter with test patterns, bit and frame clocks
//
// Operation
// - Outputs start in standard swing; strap or setting selects reduced swing.
// - One setting raises termination and drive current on all outputs together.
// - Offset binary coding by default; a setting switches to twos complement.
// - Offset binary: negative full scale 0, midscale 512, positive full scale 1023.
// - Each channel gets its own lane, ten data bits per sample period.
// - Normal lowest rate 10 MSPS; low-rate PLL setting allows 5 MSPS.
// - Bit clock runs at six times sample rate; data changes on both edges.
// - Frame clock at sample rate; its rising edge marks each word start.
// - Mode 0001 repeats midscale word, format conversion applied.
// - Mode 0010 repeats all ones, 0011 all zeros, both format converted.
// - Mode 0100 alternates 1010 and 0101 words, no format conversion.
// - Mode 0111 alternates all ones and all zeros words, unconverted.
// - Mode 1000 alternates two user words, unconverted.
// - Mode 1001 repeats alternating bits starting with one, unconverted.
// - Mode 1010 repeats sync word 00 0001 1111, unconverted.
// - Mode 1011 repeats word with only first bit set, unconverted.
// - Mode 1100 repeats mixed frequency word 10 0110 0011, unconverted.
// - Modes 0101 and 0110 send 23-bit and 9-bit pseudorandom sequences.
`timescale 1ns/1ps
`default_nettype none
module qsof_formatter
  import qsof_pkg::*;
#(
  parameter int unsigned MAX_PERIOD    = MAX_PERIOD_CYC,
  parameter int unsigned MAX_PERIOD_LO = MAX_PERIOD_LO_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 sample_clk_in,
  input  wire logic [WORD_BITS-1:0] ch0_code,
  input  wire logic [WORD_BITS-1:0] ch1_code,
  input  wire logic [WORD_BITS-1:0] ch2_code,
  input  wire logic [WORD_BITS-1:0] ch3_code,
  input  wire logic                 reduced_swing_strap_pin,
  input  wire logic                 cfg_reduced_swing,
  input  wire logic                 cfg_drive_boost,
  input  wire logic                 cfg_twos_complement,
  input  wire logic                 cfg_low_rate_pll,
  input  wire logic                 cfg_lsb_first,
  input  wire logic [3:0]           cfg_test_mode,
  input  wire logic [WORD_BITS-1:0] user_word1,
  input  wire logic [WORD_BITS-1:0] user_word2,
  output logic                      lane0_data,
  output logic                      lane1_data,
  output logic                      lane2_data,
  output logic                      lane3_data,
  output logic                      output_bit_clock,
  output logic                      frame_marker_clock,
  output logic                      reduced_swing_out,
  output logic                      drive_boost_out,
  output logic                      pll_locked
);
  // Reset release synchroniser
  logic rst_meta_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Pin synchronisers; first stages feed only the second stages
  logic samp_meta_reg;
  logic samp_sync_reg;
  logic samp_prev_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_meta_reg  <= 1'b0;
      samp_sync_reg  <= 1'b0;
      samp_prev_reg  <= 1'b0;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end else begin
      samp_meta_reg  <= sample_clk_in;
      samp_sync_reg  <= samp_meta_reg;
      samp_prev_reg  <= samp_sync_reg;
      strap_meta_reg <= reduced_swing_strap_pin;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  logic samp_edge;
  assign samp_edge = samp_sync_reg & ~samp_prev_reg;

  // Strap is caught once, after it has settled through the synchroniser
  logic [1:0] strap_cnt_reg;
  logic       strap_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= 2'h0;
      strap_reg     <= 1'b0;
    end else if (strap_cnt_reg != STRAP_CATCH_CYC) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_CATCH_CYC - 2'h1) begin
        strap_reg <= strap_sync_reg;
      end
    end
  end

  // Output driver controls; standard swing until strap or setting asks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reduced_swing_out <= 1'b0;
      drive_boost_out   <= 1'b0;
    end else begin
      reduced_swing_out <= strap_reg | cfg_reduced_swing;
      drive_boost_out   <= cfg_drive_boost;
    end
  end

  // Sample period measurement stands in for the PLL lock detector
  logic [PERIOD_W-1:0] period_cnt_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [PERIOD_W-1:0] max_period;
  logic                in_range;
  assign max_period = cfg_low_rate_pll ? PERIOD_W'(MAX_PERIOD_LO) : PERIOD_W'(MAX_PERIOD);
  assign in_range   = (period_cnt_reg + PERIOD_W'(1) >= PERIOD_W'(MIN_PERIOD_CYC))
                    && (period_cnt_reg + PERIOD_W'(1) <= max_period);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= '0;
      period_reg     <= PERIOD_W'(MIN_PERIOD_CYC);
      pll_locked     <= 1'b0;
    end else if (samp_edge) begin
      period_cnt_reg <= '0;
      period_reg     <= period_cnt_reg + PERIOD_W'(1);
      pll_locked     <= in_range;
    end else begin
      // Too slow a sample clock drops lock without waiting for an edge
      if (period_cnt_reg != '1) begin
        period_cnt_reg <= period_cnt_reg + PERIOD_W'(1);
      end
      if (period_cnt_reg >= max_period) begin
        pll_locked <= 1'b0;
      end
    end
  end

  logic frame_start;
  assign frame_start = samp_edge & in_range & pll_locked;

  // Pattern state: word alternation and pseudorandom generators step per frame
  logic                 alt_reg;
  logic [WORD_BITS-1:0] pn_long_word;
  logic [WORD_BITS-1:0] pn_short_word;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_reg <= 1'b0;
    end else if (frame_start) begin
      alt_reg <= ~alt_reg;
    end
  end

  qsof_pn_gen #(
    .WIDTH (PN_LONG_W),
    .TAP   (PN_LONG_TAP),
    .OUT_W (WORD_BITS)
  ) u_pn_long (
    .clk   (clk),
    .rst_n (rst_n),
    .step  (frame_start),
    .word  (pn_long_word)
  );

  qsof_pn_gen #(
    .WIDTH (PN_SHORT_W),
    .TAP   (PN_SHORT_TAP),
    .OUT_W (WORD_BITS)
  ) u_pn_short (
    .clk   (clk),
    .rst_n (rst_n),
    .step  (frame_start),
    .word  (pn_short_word)
  );

  // Pattern selection; fmt marks words that pass through the coding step
  logic [WORD_BITS-1:0] ch_code [LANES];
  assign ch_code[0] = ch0_code;
  assign ch_code[1] = ch1_code;
  assign ch_code[2] = ch2_code;
  assign ch_code[3] = ch3_code;

  logic                 use_pattern;
  logic                 pat_fmt;
  logic [WORD_BITS-1:0] pat_word;
  always_comb begin
    use_pattern = 1'b1;
    pat_fmt     = 1'b0;
    pat_word    = CODE_ALL_ZEROS;
    case (qsof_test_mode_t'(cfg_test_mode))
      QSOF_TM_MIDSCALE: begin
        pat_word = CODE_MIDSCALE;
        pat_fmt  = 1'b1;
      end
      QSOF_TM_POS_FULL: begin
        pat_word = CODE_ALL_ONES;
        pat_fmt  = 1'b1;
      end
      QSOF_TM_NEG_FULL: begin
        pat_word = CODE_ALL_ZEROS;
        pat_fmt  = 1'b1;
      end
      QSOF_TM_CHECKER: begin
        pat_word = alt_reg ? CODE_CHECKER_B : CODE_CHECKER_A;
      end
      QSOF_TM_PN_LONG: begin
        pat_word = pn_long_word;
        pat_fmt  = 1'b1;
      end
      QSOF_TM_PN_SHORT: begin
        pat_word = pn_short_word;
        pat_fmt  = 1'b1;
      end
      QSOF_TM_WORD_TOG: begin
        pat_word = alt_reg ? CODE_ALL_ZEROS : CODE_ALL_ONES;
      end
      QSOF_TM_USER: begin
        pat_word = alt_reg ? user_word2 : user_word1;
      end
      QSOF_TM_BIT_TOG: begin
        pat_word = CODE_CHECKER_A;
      end
      QSOF_TM_SYNC: begin
        pat_word = CODE_SYNC;
      end
      QSOF_TM_ONE_HIGH: begin
        pat_word = CODE_MIDSCALE;
      end
      QSOF_TM_MIXED: begin
        pat_word = CODE_MIXED;
      end
      default: begin
        use_pattern = 1'b0;
      end
    endcase
  end

  // Word per lane: coding applied to live data and to format-following patterns
  logic [WORD_BITS-1:0]   lane_word  [LANES];
  logic [FRAME_SLOTS-1:0] lane_frame [LANES];
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      logic [WORD_BITS-1:0] raw;
      raw = use_pattern ? pat_word : ch_code[l];
      // Offset binary is the native code; twos complement flips the top bit
      if ((!use_pattern || pat_fmt) && cfg_twos_complement) begin
        lane_word[l] = {~raw[WORD_BITS-1], raw[WORD_BITS-2:0]};
      end else begin
        lane_word[l] = raw;
      end
      // Bit order chosen here so the shifter always sends its top bit first
      if (cfg_lsb_first) begin
        lane_frame[l] = '0;
        for (int b = 0; b < WORD_BITS; b++) begin
          lane_frame[l][FRAME_SLOTS-1-b] = lane_word[l][b];
        end
      end else begin
        lane_frame[l] = {lane_word[l], {STUFF_BITS{1'b0}}};
      end
    end
  end

  // Slot strobe: eleven per measured period after the frame edge, by a fractional accumulator
  logic [PERIOD_W-1:0] acc_reg;
  logic [PERIOD_W:0]   acc_sum;
  logic                slot_strobe;
  logic [3:0]          slot_reg;
  assign acc_sum     = {1'b0, acc_reg} + (PERIOD_W+1)'(FRAME_SLOTS);
  assign slot_strobe = (acc_sum >= {1'b0, period_reg}) && (slot_reg < 4'(FRAME_SLOTS));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg  <= '0;
      slot_reg <= 4'(FRAME_SLOTS);
    end else if (frame_start) begin
      acc_reg  <= '0;
      slot_reg <= 4'h1;
    end else if (!pll_locked) begin
      slot_reg <= 4'(FRAME_SLOTS);
    end else if (slot_strobe) begin
      acc_reg  <= PERIOD_W'(acc_sum - {1'b0, period_reg});
      slot_reg <= slot_reg + 4'h1;
    end else if (slot_reg < 4'(FRAME_SLOTS)) begin
      acc_reg  <= PERIOD_W'(acc_sum);
    end
  end

  // Lane shifters: first bit leaves with the frame edge, then one per slot
  logic [FRAME_SLOTS-1:0] shift_reg [LANES];
  logic [LANES-1:0]       lane_bit_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_bit_reg <= '0;
      for (int l = 0; l < LANES; l++) begin
        shift_reg[l] <= '0;
      end
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (frame_start) begin
          lane_bit_reg[l] <= lane_frame[l][FRAME_SLOTS-1];
          shift_reg[l]    <= lane_frame[l] << 1;
        end else if (!pll_locked) begin
          lane_bit_reg[l] <= 1'b0;
        end else if (slot_strobe) begin
          lane_bit_reg[l] <= shift_reg[l][FRAME_SLOTS-1];
          shift_reg[l]    <= shift_reg[l] << 1;
        end
      end
    end
  end

  assign lane0_data = lane_bit_reg[0];
  assign lane1_data = lane_bit_reg[1];
  assign lane2_data = lane_bit_reg[2];
  assign lane3_data = lane_bit_reg[3];

  // Frame marker high for the first half of the slots
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_marker_clock <= 1'b0;
    end else if (frame_start) begin
      frame_marker_clock <= 1'b1;
    end else if (!pll_locked) begin
      frame_marker_clock <= 1'b0;
    end else if (slot_strobe && slot_reg == 4'(MARK_HIGH_SLOTS)) begin
      frame_marker_clock <= 1'b0;
    end
  end

  // Bit clock toggles one cycle after each data change so both edges sit
  // after the data has moved; a finer phase would need a faster clock
  logic bit_toggle_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_toggle_reg   <= 1'b0;
      output_bit_clock <= 1'b0;
    end else begin
      bit_toggle_reg <= frame_start | (slot_strobe & pll_locked);
      if (frame_start) begin
        // Each frame restarts from low so twelve toggles give six periods
        output_bit_clock <= 1'b0;
      end else if (!pll_locked) begin
        output_bit_clock <= 1'b0;
      end else if (bit_toggle_reg) begin
        output_bit_clock <= ~output_bit_clock;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/qsof_formatter_assertions.sv ====
// Port-level checks on the serial output formatter
`timescale 1ns/1ps
`default_nettype none
module qsof_formatter_assertions
  import qsof_pkg::*;
#(
  parameter int unsigned MAX_PERIOD_LO = MAX_PERIOD_LO_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfg_reduced_swing,
  input wire logic cfg_drive_boost,
  input wire logic lane0_data,
  input wire logic lane1_data,
  input wire logic lane2_data,
  input wire logic lane3_data,
  input wire logic output_bit_clock,
  input wire logic frame_marker_clock,
  input wire logic reduced_swing_out,
  input wire logic drive_boost_out,
  input wire logic pll_locked
);
  logic [2:0] up_reg;
  logic       bclk_reg;
  logic       frame_reg;
  logic       seen_reg;
  logic [4:0] tog_reg;
  logic [5:0] gap_reg;
  logic [4:0] tog_now;
  logic       rise;
  logic       lanes;
  // Toggles counted inclusive of this cycle, since a coinciding edge belongs to the old frame
  assign tog_now = tog_reg + 5'(output_bit_clock ^ bclk_reg);
  assign rise    = frame_marker_clock & ~frame_reg;
  assign lanes   = lane0_data | lane1_data | lane2_data | lane3_data;
  // Frame bookkeeping; seen_reg drops on unlock so partial frames are not judged
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_reg    <= 3'h0;
      bclk_reg  <= 1'b0;
      frame_reg <= 1'b0;
      seen_reg  <= 1'b0;
      tog_reg   <= 5'h0;
      gap_reg   <= 6'h0;
    end else begin
      up_reg    <= up_reg + 3'(up_reg != 3'h7);
      bclk_reg  <= output_bit_clock;
      frame_reg <= frame_marker_clock;
      tog_reg   <= rise ? 5'h0 : tog_now;
      gap_reg   <= rise ? 6'h1 : gap_reg + 6'(gap_reg != 6'h3f);
      seen_reg  <= pll_locked & (seen_reg | rise);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_swing_follow: assert property (up_reg == 3'h7 && $past(cfg_reduced_swing) |-> reduced_swing_out)
    else $error("reduced swing not selected");
  a_boost_follow: assert property (up_reg == 3'h7 |-> drive_boost_out == $past(cfg_drive_boost))
    else $error("drive boost output wrong");
  a_rise_clk_low: assert property (rise |-> !output_bit_clock)
    else $error("bit clock high at word start");
  a_twelve_edges: assert property (rise && seen_reg && pll_locked |-> tog_now == 5'd12)
    else $error("bit clock edge count per frame wrong");
  a_six_high: assert property ($fell(frame_marker_clock) && seen_reg && pll_locked |-> tog_now == 5'd6)
    else $error("frame marker high span wrong");
  a_frame_gap: assert property (rise && seen_reg |-> gap_reg >= MIN_PERIOD_CYC && gap_reg <= MAX_PERIOD_LO)
    else $error("frame spacing out of range");
  a_unlock_quiet: assert property (!pll_locked [*3] |-> !frame_marker_clock && !output_bit_clock && !lanes)
    else $error("outputs active while unlocked");
  a_stuff_zero: assert property (rise && seen_reg |-> !$past(lanes))
    else $error("stuff slots not zero");
  c_frame: cover property (rise && seen_reg);
  c_unlock: cover property ($fell(pll_locked));
  c_swing: cover property ($rose(reduced_swing_out));
endmodule
`default_nettype wire

// ==== testbench/qsof_lvds_rx.sv ====
// Receiver model: captures each lane on both bit clock edges, words framed by the marker
`timescale 1ns/1ps
`default_nettype none
module qsof_lvds_rx (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] lanes,
  input  wire logic       bit_clk,
  input  wire logic       frame,
  output logic      [9:0] rx_last [4],
  output logic      [9:0] rx_prev [4],
  output int              rx_count
);
  logic [3:0] lane_reg;
  logic       bclk_reg;
  logic       frame_reg;
  logic [3:0] cnt_reg;
  logic [9:0] sh_reg [4];
  // Lane value is taken from the cycle before the edge, since data may move again at the edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lane_reg  <= 4'h0;
      bclk_reg  <= 1'b0;
      frame_reg <= 1'b0;
      cnt_reg   <= 4'hf;
      rx_count  <= 0;
      for (int i = 0; i < 4; i++) begin
        sh_reg[i]  <= 10'h000;
        rx_last[i] <= 10'h000;
        rx_prev[i] <= 10'h000;
      end
    end else begin
      lane_reg  <= lanes;
      bclk_reg  <= bit_clk;
      frame_reg <= frame;
      if (frame && !frame_reg) begin
        cnt_reg <= 4'h0; // Word starts at marker rise
      end else if (bit_clk != bclk_reg && cnt_reg < 4'd10) begin
        cnt_reg <= cnt_reg + 4'h1; // Both edges carry a bit
        for (int i = 0; i < 4; i++) begin
          sh_reg[i] <= {sh_reg[i][8:0], lane_reg[i]};
          if (cnt_reg == 4'd9) begin
            rx_prev[i] <= rx_last[i];
            rx_last[i] <= {sh_reg[i][8:0], lane_reg[i]};
          end
        end
        if (cnt_reg == 4'd9) begin
          rx_count <= rx_count + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/quad_adc_serial_output_formatter_tb.sv ====
// Self-checking bench for the formatter with receiver model and reference words
`timescale 1ns/1ps
`default_nettype none
module quad_adc_serial_output_formatter_tb
  import qsof_pkg::*;
;
  logic clk, rstn, samp, strap, swing, boost, tc, lopll, lsb;
  logic [3:0] mode;
  logic [9:0] ch [4];
  logic [9:0] u1, u2;
  wire logic [3:0] lanes;
  logic bclk, fclk, swo, bo, lock;
  logic [9:0] rx_last [4];
  logic [9:0] rx_prev [4];
  int rx_count, miscompares, tests_run;
  logic [31:0] rs;
  qsof_formatter #(.MAX_PERIOD(10), .MAX_PERIOD_LO(20)) DUT (.clk(clk), .rstn(rstn), .sample_clk_in(samp),
    .ch0_code(ch[0]), .ch1_code(ch[1]), .ch2_code(ch[2]), .ch3_code(ch[3]), .reduced_swing_strap_pin(strap),
    .cfg_reduced_swing(swing), .cfg_drive_boost(boost), .cfg_twos_complement(tc), .cfg_low_rate_pll(lopll),
    .cfg_lsb_first(lsb), .cfg_test_mode(mode), .user_word1(u1), .user_word2(u2), .lane0_data(lanes[0]),
    .lane1_data(lanes[1]), .lane2_data(lanes[2]), .lane3_data(lanes[3]), .output_bit_clock(bclk),
    .frame_marker_clock(fclk), .reduced_swing_out(swo), .drive_boost_out(bo), .pll_locked(lock));
  qsof_lvds_rx u_rx (.clk(clk), .rstn(rstn), .lanes(lanes), .bit_clk(bclk), .frame(fclk),
    .rx_last(rx_last), .rx_prev(rx_prev), .rx_count(rx_count));
  // System clock and a free-running 160 ns sample clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    samp = 1'b0;
    #3;
    forever #80 samp = ~samp;
  end
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for the receiver to deliver n more words
  task automatic wait_words(input int n);
    int t0, k;
    t0 = rx_count;
    k = 0;
    while (rx_count < t0 + n && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      miscompares++;
      $display("unexpected at %0t: word wait ran out", $time);
    end
  endtask
  // Reference word pair per mode; twos complement flips only the top bit
  function automatic logic [19:0] pair(int m, logic [9:0] c);
    logic [9:0] f;
    f = tc ? 10'h200 : 10'h000;
    case (m)
      1: return {2{10'h200 ^ f}};
      2: return {2{10'h3ff ^ f}};
      3: return {2{f}};
      4: return {10'h2aa, 10'h155};
      7: return {10'h3ff, 10'h000};
      8: return {u1, u2};
      9: return {2{10'h2aa}};
      10: return {2{10'h01f}};
      11: return {2{10'h200}};
      12: return {2{10'h263}};
      default: return {2{c ^ f}};
    endcase
  endfunction
  function automatic logic [9:0] rev(logic [9:0] w);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) r[i] = w[9-i];
    return r;
  endfunction
  // Reference pseudorandom word of frame n: all-ones seed word first, then ten new bits per frame
  function automatic logic [9:0] pn_ref(int w, int tap, int n);
    logic [22:0] s;
    logic [9:0] o;
    logic b;
    s = 23'h7fffff;
    o = 10'h3ff;
    for (int j = 1; j < n; j++) begin
      for (int k = 0; k < 10; k++) begin
        b = s[w-1] ^ s[tap-1];
        o = {o[8:0], b};
        s = {s[21:0], b};
      end
    end
    return o;
  endfunction
  task automatic run_cfg(input int m, input logic t, input logic l);
    logic [19:0] p;
    logic [9:0] wa, wb;
    @(posedge clk);
    rs = xs(rs);
    mode <= 4'(m);
    tc <= t;
    lsb <= l;
    swing <= rs[0];
    boost <= rs[1];
    ch[3] <= rs[13:4];
    u1 <= rs[23:14];
    u2 <= ~rs[23:14];
    wait_words(3);
    for (int i = 0; i < 4; i++) begin
      p = pair(m, ch[i]);
      if (m == 5 || m == 6) begin
        // Last two received words belong to frames rx_count and rx_count - 1
        p[19:10] = pn_ref((m == 5) ? 23 : 9, (m == 5) ? 18 : 5, rx_count);
        p[9:0] = pn_ref((m == 5) ? 23 : 9, (m == 5) ? 18 : 5, rx_count - 1);
        p = p ^ (tc ? 20'h80200 : 20'h00000);
      end
      wa = l ? rev(p[19:10]) : p[19:10];
      wb = l ? rev(p[9:0]) : p[9:0];
      if (m == 5 || m == 6) begin
        check(rx_last[i], wa, "pn word");
        check(rx_prev[i], wb, "previous pn word");
      end else begin
        check(rx_last[i], (rx_last[i] === wa) ? wa : wb, "word");
        check(rx_prev[i], (rx_last[i] === wa) ? wb : wa, "previous word");
      end
    end
    check({9'h0, swo}, {9'h0, swing}, "swing output");
    check({9'h0, bo}, {9'h0, boost}, "boost output");
    $display("test mode %0d coding %0d order %0d done", m, t, l);
  endtask
  // Watchdog: 35 configurations of three frames each fit well inside this span
  initial begin
    #200_000;
    miscompares++;
    $display("unexpected at %0t: run timed out", $time);
    test_done();
  end
  initial begin
    rs = 32'h8f0d;
    rstn = 1'b0;
    {strap, swing, boost, tc, lsb} = 5'h00;
    lopll = 1'b1;
    mode = 4'h0;
    ch[0] = 10'h000;
    ch[1] = 10'h200;
    ch[2] = 10'h3ff;
    ch[3] = 10'h000;
    u1 = 10'h000;
    u2 = 10'h000;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check({9'h0, swo}, 10'h000, "standard swing after reset");
    wait_words(1);
    $display("test reset and lock done");
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 16; m++) run_cfg(m, t[0], 1'b0);
    end
    run_cfg(0, 1'b0, 1'b1);
    run_cfg(12, 1'b1, 1'b1);
    run_cfg(8, 1'b0, 1'b1);
    // Normal PLL range cannot hold a 160 ns period
    @(posedge clk);
    lopll <= 1'b0;
    repeat (100) @(posedge clk);
    check({9'h0, lock}, 10'h000, "lock held at slow rate");
    check({4'h0, lanes, bclk, fclk}, 10'h000, "outputs while unlocked");
    lopll <= 1'b1;
    wait_words(2);
    check({9'h0, lock}, 10'h001, "lock with low rate setting");
    $display("test lock range done");
    // Second reset with the strap high: reduced swing without the setting
    strap <= 1'b1;
    swing <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check({9'h0, swo}, 10'h001, "strap selects reduced swing");
    $display("test strap done");
    test_done();
  end
endmodule
bind qsof_formatter qsof_formatter_assertions #(.MAX_PERIOD_LO(MAX_PERIOD_LO)) u_chk (.clk(clk), .rstn(rstn),
  .cfg_reduced_swing(cfg_reduced_swing), .cfg_drive_boost(cfg_drive_boost), .lane0_data(lane0_data),
  .lane1_data(lane1_data), .lane2_data(lane2_data), .lane3_data(lane3_data), .output_bit_clock(output_bit_clock),
  .frame_marker_clock(frame_marker_clock), .reduced_swing_out(reduced_swing_out), .drive_boost_out(drive_boost_out),
  .pll_locked(pll_locked));
`default_nettype wire
